// ===== common/drive_output_pkg.sv
// constants shared by the output terminal selector and its pulse generator
// assumes a single 125 MHz system clock and status inputs from the same domain
package drive_output_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 125_000_000;
  localparam int unsigned PULSE_MAX_HZ = 100_000;
  localparam int unsigned PULSE_MIN_HALF = (CLK_FREQ_HZ + 2 * PULSE_MAX_HZ - 1) / (2 * PULSE_MAX_HZ);
  localparam int unsigned SEQ_PULSE_MS = 250;
  localparam int unsigned SEQ_PULSE_CYCLES = CLK_FREQ_HZ / 1000 * SEQ_PULSE_MS;
  localparam int unsigned OVERLOAD_PREWARN_S = 10;
  localparam int unsigned OVERLOAD_PREWARN_MS = OVERLOAD_PREWARN_S * 1000;

  // ----------------------------------------
  // selectors
  // ----------------------------------------
  localparam int unsigned NUM_OUTPUTS = 5;
  localparam int unsigned SEL_W = 6;
  localparam logic [5:0] SEL_MAX = 6'h29;
  localparam int unsigned NUM_CODES = 42;
  // output index order
  localparam int unsigned OUT_SWITCH = 0;
  localparam int unsigned OUT_BOARD_RELAY = 1;
  localparam int unsigned OUT_EXT_RELAY = 2;
  localparam int unsigned OUT_TRANSISTOR_ONE = 3;
  localparam int unsigned OUT_EXT_TRANSISTOR = 4;
  localparam logic [5:0] RST_SEL_SWITCH = 6'h00;
  localparam logic [5:0] RST_SEL_BOARD_RELAY = 6'h02;
  localparam logic [5:0] RST_SEL_EXT_RELAY = 6'h00;
  localparam logic [5:0] RST_SEL_TRANSISTOR_ONE = 6'h01;
  localparam logic [5:0] RST_SEL_EXT_TRANSISTOR = 6'h04;
  localparam logic RST_MODE = 1'b0;
  localparam logic [15:0] RST_HALF_PERIOD = 16'h04e2;

  // ----------------------------------------
  // register map (byte offsets)
  // ----------------------------------------
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] REG_MODE = 6'h00;
  localparam logic [5:0] REG_SEL_BASE = 6'h04;
  localparam logic [5:0] REG_HALF_PERIOD = 6'h18;
  localparam logic [5:0] REG_SET_COUNT = 6'h1c;
  localparam logic [5:0] REG_DSG_COUNT = 6'h20;
  localparam logic [5:0] REG_LENGTH_SP = 6'h24;
  localparam logic [5:0] REG_RUNTIME_SP = 6'h28;
  localparam logic [5:0] REG_STATUS = 6'h2c;

endpackage

// ===== common/pulse_gen_if.sv
// link between the selector and its pulse train generator
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface pulse_gen_if;
  logic enable;
  logic [15:0] half_period;
  logic pulse;
  modport ctrl (output enable, output half_period, input pulse);
  modport gen (input enable, input half_period, output pulse);
endinterface

// ===== logic/drive_output_terminal_mux.sv
// output terminal function selector with avalon-mm register slave
// assumes all status inputs come from the drive core on clk_sys_i
`timescale 1ns/1ps
module drive_output_terminal_mux
  import drive_output_pkg::*;
#(
  parameter int unsigned SEQ_PULSE_LEN = SEQ_PULSE_CYCLES,
  parameter int unsigned ANALOG_W = 12
)
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // register bus
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // drive status
  input wire logic drive_running_i,
  input wire logic fault_stop_i,
  input wire logic fault_present_i,
  input wire logic freq_level_detect_one_i,
  input wire logic freq_reached_i,
  input wire logic output_freq_zero_i,
  input wire logic motor_load_over_prewarn_i,
  input wire logic drive_overload_accum_i,
  input wire logic [15:0] drive_overload_ms_left_i,
  input wire logic [31:0] count_value_i,
  input wire logic [31:0] actual_length_i,
  input wire logic [31:0] run_time_i,
  input wire logic step_sequencer_cycle_done_i,
  input wire logic set_freq_above_upper_i,
  input wire logic set_freq_below_lower_i,
  input wire logic run_freq_at_upper_i,
  input wire logic run_freq_at_lower_i,
  input wire logic power_stable_i,
  input wire logic control_stable_i,
  input wire logic [ANALOG_W-1:0] voltage_analog_input_i,
  input wire logic [ANALOG_W-1:0] second_analog_input_i,
  // terminals
  output logic multiplexed_terminal_o,
  output logic switch_signal_output_o,
  output logic board_relay_o,
  output logic extension_relay_o,
  output logic transistor_output_one_o,
  output logic extension_transistor_output_o
);

  localparam int unsigned SEQ_W = $clog2(SEQ_PULSE_LEN + 1);

  typedef struct packed {
    logic mode;
    logic [NUM_OUTPUTS-1:0][SEL_W-1:0] sel;
    logic [15:0] half_period;
    logic [31:0] set_count;
    logic [31:0] dsg_count;
    logic [31:0] length_sp;
    logic [31:0] runtime_sp;
    logic [SEQ_W-1:0] seq_cnt;
    logic ack;
    logic [31:0] rdata;
    logic [NUM_OUTPUTS-1:0] outs;
    logic term;
  } state_type;

  state_type state_reg;
  state_type state_next;
  logic [NUM_CODES-1:0] cond;
  logic [NUM_OUTPUTS-1:0] hit;
  logic pulse;

  pulse_gen_if pg ();

  // ----------------------------------------
  // pulse train generator
  // ----------------------------------------
  assign pg.enable = (state_reg.mode == 1'b0);
  assign pg.half_period = state_reg.half_period;
  assign pulse = pg.pulse;

  pulse_train_gen u_pulse_train_gen (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .pg(pg)
  );

  // ----------------------------------------
  // status conditions by code
  // ----------------------------------------
  always_comb begin
    cond = '0;
    cond[0] = 1'b0;
    cond[1] = drive_running_i;
    cond[2] = fault_stop_i;
    cond[3] = freq_level_detect_one_i;
    cond[4] = freq_reached_i;
    cond[5] = drive_running_i & output_freq_zero_i;
    cond[6] = motor_load_over_prewarn_i;
    cond[7] = drive_overload_accum_i
              & (drive_overload_ms_left_i <= 16'(OVERLOAD_PREWARN_MS));
    cond[8] = (count_value_i >= state_reg.set_count);
    cond[9] = (count_value_i >= state_reg.dsg_count);
    cond[10] = (actual_length_i > state_reg.length_sp);
    cond[11] = (state_reg.seq_cnt != '0);
    cond[12] = (run_time_i > state_reg.runtime_sp);
    cond[13] = (set_freq_above_upper_i & run_freq_at_upper_i)
               | (set_freq_below_lower_i & run_freq_at_lower_i);
    cond[14] = 1'b0;
    cond[15] = power_stable_i & control_stable_i & ~fault_present_i;
    cond[16] = (voltage_analog_input_i > second_analog_input_i);
    cond[17] = run_freq_at_upper_i;
    cond[18] = run_freq_at_lower_i | ~drive_running_i;
    // codes 19 and up are served elsewhere and read as off here
  end

  // ----------------------------------------
  // per-output selection
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUTPUTS; gi++) begin : g_sel
      // out of range codes cannot be stored, but guard anyway
      assign hit[gi] = (state_reg.sel[gi] <= SEL_MAX) ? cond[state_reg.sel[gi]]
                                                      : 1'b0;
    end
  endgenerate

  // ----------------------------------------
  // register access
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  always_comb begin
    logic [31:0] wv;
    logic [2:0] idx;
    wv = '0;
    idx = '0;
    state_next = state_reg;
    state_next.ack = 1'b0;
    state_next.outs = hit;
    state_next.term = state_reg.mode ? state_reg.outs[OUT_SWITCH] : pulse;

    // retrigger restarts the full width
    if (step_sequencer_cycle_done_i) begin
      state_next.seq_cnt = SEQ_W'(SEQ_PULSE_LEN);
    end else if (state_reg.seq_cnt != '0) begin
      state_next.seq_cnt = state_reg.seq_cnt - SEQ_W'(1);
    end

    if ((avs_read_i | avs_write_i) && !state_reg.ack) begin
      state_next.ack = 1'b1;
      state_next.rdata = '0;
      case (avs_address_i)
        REG_MODE: begin
          state_next.rdata = {31'h0, state_reg.mode};
          if (avs_write_i) begin
            wv = merge({31'h0, state_reg.mode}, avs_writedata_i, avs_byteenable_i);
            state_next.mode = wv[0];
          end
        end
        REG_SEL_BASE, REG_SEL_BASE + 6'h04, REG_SEL_BASE + 6'h08,
        REG_SEL_BASE + 6'h0c, REG_SEL_BASE + 6'h10: begin
          idx = 3'((avs_address_i - REG_SEL_BASE) >> 2);
          state_next.rdata = {26'h0, state_reg.sel[idx]};
          if (avs_write_i) begin
            wv = merge({26'h0, state_reg.sel[idx]}, avs_writedata_i, avs_byteenable_i);
            // codes above the top are dropped, old code kept
            if (wv <= {26'h0, SEL_MAX}) begin
              state_next.sel[idx] = wv[SEL_W-1:0];
            end
          end
        end
        REG_HALF_PERIOD: begin
          state_next.rdata = {16'h0, state_reg.half_period};
          if (avs_write_i) begin
            wv = merge({16'h0, state_reg.half_period}, avs_writedata_i, avs_byteenable_i);
            state_next.half_period = wv[15:0];
          end
        end
        REG_SET_COUNT: begin
          state_next.rdata = state_reg.set_count;
          if (avs_write_i) begin
            state_next.set_count = merge(state_reg.set_count, avs_writedata_i, avs_byteenable_i);
          end
        end
        REG_DSG_COUNT: begin
          state_next.rdata = state_reg.dsg_count;
          if (avs_write_i) begin
            state_next.dsg_count = merge(state_reg.dsg_count, avs_writedata_i, avs_byteenable_i);
          end
        end
        REG_LENGTH_SP: begin
          state_next.rdata = state_reg.length_sp;
          if (avs_write_i) begin
            state_next.length_sp = merge(state_reg.length_sp, avs_writedata_i, avs_byteenable_i);
          end
        end
        REG_RUNTIME_SP: begin
          state_next.rdata = state_reg.runtime_sp;
          if (avs_write_i) begin
            state_next.runtime_sp = merge(state_reg.runtime_sp, avs_writedata_i,
                                          avs_byteenable_i);
          end
        end
        REG_STATUS: begin
          state_next.rdata = {25'h0, state_reg.term, state_reg.mode, state_reg.outs};
        end
        default: begin
          state_next.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= '0;
      state_reg.mode <= RST_MODE;
      state_reg.sel[OUT_SWITCH] <= RST_SEL_SWITCH;
      state_reg.sel[OUT_BOARD_RELAY] <= RST_SEL_BOARD_RELAY;
      state_reg.sel[OUT_EXT_RELAY] <= RST_SEL_EXT_RELAY;
      state_reg.sel[OUT_TRANSISTOR_ONE] <= RST_SEL_TRANSISTOR_ONE;
      state_reg.sel[OUT_EXT_TRANSISTOR] <= RST_SEL_EXT_TRANSISTOR;
      state_reg.half_period <= RST_HALF_PERIOD;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~state_reg.ack;
  assign avs_readdata_o = state_reg.rdata;
  assign multiplexed_terminal_o = state_reg.term;
  assign switch_signal_output_o = state_reg.outs[OUT_SWITCH];
  assign board_relay_o = state_reg.outs[OUT_BOARD_RELAY];
  assign extension_relay_o = state_reg.outs[OUT_EXT_RELAY];
  assign transistor_output_one_o = state_reg.outs[OUT_TRANSISTOR_ONE];
  assign extension_transistor_output_o = state_reg.outs[OUT_EXT_TRANSISTOR];

endmodule

// ===== logic/pulse_train_gen.sv
// square wave generator for the multiplexed terminal in pulse mode
// assumes half period in system clock cycles, set by software
`timescale 1ns/1ps
module pulse_train_gen
  import drive_output_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  pulse_gen_if.gen pg
);

  typedef struct packed {
    logic [15:0] cnt;
    logic level;
  } gen_state_type;

  gen_state_type state_reg;
  gen_state_type state_next;
  logic [15:0] half_eff;

  // ----------------------------------------
  // divider
  // ----------------------------------------
  // short settings would exceed the top rate, so they are raised
  assign half_eff = (pg.half_period < 16'(PULSE_MIN_HALF)) ? 16'(PULSE_MIN_HALF)
                                                           : pg.half_period;

  always_comb begin
    state_next = state_reg;
    if (!pg.enable) begin
      state_next.cnt = 16'h0000;
      state_next.level = 1'b0;
    end else if (state_reg.cnt >= half_eff - 16'h0001) begin
      state_next.cnt = 16'h0000;
      state_next.level = ~state_reg.level;
    end else begin
      state_next.cnt = state_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pg.pulse = state_reg.level;

endmodule

// ===== verification/drive_output_terminal_mux_bench.sv
// self-checking bench for the terminal selector
// assumes the field wiring model and the bound checker
`timescale 1ns/1ps
module drive_output_terminal_mux_bench
  import drive_output_pkg::*;
;
  typedef struct packed {logic [5:0] c; logic [14:0] s; logic [31:0] v; logic e;} row_type;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic rd = 1'b0, wr = 1'b0, clr = 1'b1;
  logic [5:0] adr = 6'h00;
  logic [14:0] st = 15'h0000;
  logic [31:0] wd = 32'h0, num = 32'h0, q, rdata;
  logic wreq, term, sw, brel, xrel, t1, xt;
  int n_errors = 0, comparisons = 0, min_run, edges;
  row_type rows [] = '{'{6'h00,15'h7fff,32'hc8,1'b0},
    '{6'h01,15'h0001,32'h0,1'b1}, '{6'h01,15'h0020,32'h0,1'b0},
    '{6'h02,15'h0002,32'h0,1'b1}, '{6'h02,15'h0005,32'h0,1'b0},
    '{6'h05,15'h0021,32'h0,1'b1}, '{6'h05,15'h0020,32'h0,1'b0},
    '{6'h06,15'h0040,32'h0,1'b1}, '{6'h03,15'h0008,32'h0,1'b1},
    '{6'h07,15'h0080,32'h2710,1'b1}, '{6'h07,15'h0080,32'h2711,1'b0},
    '{6'h08,15'h0,32'h64,1'b1}, '{6'h08,15'h0,32'h63,1'b0},
    '{6'h09,15'h0,32'h32,1'b1}, '{6'h09,15'h0,32'h31,1'b0},
    '{6'h0a,15'h0,32'h65,1'b1}, '{6'h0a,15'h0,32'h64,1'b0},
    '{6'h0c,15'h0,32'h65,1'b1}, '{6'h0c,15'h0,32'h64,1'b0},
    '{6'h0d,15'h0a00,32'h0,1'b1}, '{6'h0d,15'h1400,32'h0,1'b1},
    '{6'h0d,15'h1200,32'h0,1'b0},
    '{6'h0f,15'h6000,32'h0,1'b1}, '{6'h0f,15'h6004,32'h0,1'b0},
    '{6'h10,15'h0,32'h65,1'b1}, '{6'h10,15'h0,32'h64,1'b0},
    '{6'h11,15'h0800,32'h0,1'b1}, '{6'h12,15'h0001,32'h0,1'b0},
    '{6'h12,15'h0,32'h0,1'b1}, '{6'h12,15'h1001,32'h0,1'b1},
    '{6'h0e,15'h7fff,32'hffff,1'b0}, '{6'h15,15'h7fff,32'hffff,1'b0},
    '{6'h29,15'h7fff,32'hffff,1'b0}};
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // short sequencer pulse keeps the run brief
  drive_output_terminal_mux #(.SEQ_PULSE_LEN(20)) dut_u (.clk_sys_i, .sys_rst_i,
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .drive_running_i(st[0]), .fault_stop_i(st[1]), .fault_present_i(st[2]),
    .freq_level_detect_one_i(st[3]), .freq_reached_i(st[4]), .output_freq_zero_i(st[5]),
    .motor_load_over_prewarn_i(st[6]), .drive_overload_accum_i(st[7]),
    .drive_overload_ms_left_i(num[15:0]), .count_value_i(num), .actual_length_i(num),
    .run_time_i(num), .step_sequencer_cycle_done_i(st[8]), .set_freq_above_upper_i(st[9]),
    .set_freq_below_lower_i(st[10]), .run_freq_at_upper_i(st[11]),
    .run_freq_at_lower_i(st[12]), .power_stable_i(st[13]), .control_stable_i(st[14]),
    .voltage_analog_input_i(num[11:0]), .second_analog_input_i(12'h064),
    .multiplexed_terminal_o(term), .switch_signal_output_o(sw), .board_relay_o(brel),
    .extension_relay_o(xrel), .transistor_output_one_o(t1),
    .extension_transistor_output_o(xt));
  field_wiring_model fw_u (.clk_sys_i, .clr_i(clr), .term_i(term), .min_run_o(min_run),
    .edges_o(edges));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task summarize;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  // one idle edge before each request keeps drivers single per step
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 40) chk(32'(wreq), 32'h0);
  endtask
  task rdc(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task put(input logic [14:0] s, input logic [31:0] v, input int c);
    @(posedge clk_sys_i);
    st <= s;
    num <= v;
    repeat (c) @(posedge clk_sys_i);
  endtask
  // worst case run is about 6400 cycles
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    n_errors++;
    summarize();
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    int n;
    repeat (6) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rdc(6'h00, 32'h0);
    rdc(6'h04, 32'h0);
    rdc(6'h08, 32'h2);
    rdc(6'h0c, 32'h0);
    rdc(6'h10, 32'h1);
    rdc(6'h14, 32'h4);
    rdc(6'h30, 32'h0);
    put(15'h0013, 32'h0, 2);
    chk({brel, t1, xt, sw, xrel}, 32'h1c);
    clr <= 1'b0;
    put(15'h0, 32'h0, 3000);
    chk(32'(edges >= 2 && min_run >= 1250), 32'h1);
    bus(1'b1, 6'h1c, 32'h64);
    bus(1'b1, 6'h20, 32'h32);
    bus(1'b1, 6'h24, 32'h64);
    bus(1'b1, 6'h28, 32'h64);
    foreach (rows[i]) begin
      bus(1'b1, 6'h08, 32'(rows[i].c));
      put(rows[i].s, rows[i].v, 2);
      chk({brel, t1}, {rows[i].e, rows[i].s[0]});
    end
    // the last rows hold the done pulse high, so let the old pulse run out first
    put(15'h0, 32'h0, 25);
    bus(1'b1, 6'h08, 32'h0b);
    @(posedge clk_sys_i);
    st <= 15'h0100;
    @(posedge clk_sys_i);
    st <= 15'h0;
    n = 0;
    repeat (40) begin
      @(posedge clk_sys_i);
      if (brel === 1'b1) n++;
    end
    chk(n, 32'd20);
    bus(1'b1, 6'h08, 32'h2a);
    rdc(6'h08, 32'h0b);
    bus(1'b1, 6'h04, 32'h1);
    bus(1'b1, 6'h0c, 32'h1);
    bus(1'b1, 6'h00, 32'h1);
    put(15'h0001, 32'h0, 3);
    chk(32'(term), 32'h1);
    chk({sw, xrel}, 32'h3);
    put(15'h0, 32'h0, 3);
    chk(32'(term), 32'h0);
    chk({sw, xrel}, 32'h0);
    bus(1'b1, 6'h18, 32'h0a);
    bus(1'b1, 6'h00, 32'h0);
    clr <= 1'b1;
    put(15'h0, 32'h0, 1);
    clr <= 1'b0;
    put(15'h0, 32'h0, 3000);
    chk(32'(edges >= 4 && min_run >= 625), 32'h1);
    sys_rst_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rdc(6'h08, 32'h2);
    rdc(6'h18, 32'h4e2);
    summarize();
  end
endmodule

// ===== verification/drive_output_terminal_mux_properties.sv
// checks the terminal selector at its top ports
// assumes reset selector codes until the first register write
`timescale 1ns/1ps
module drive_output_terminal_mux_properties
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic drive_running_i,
  input wire logic fault_stop_i,
  input wire logic freq_reached_i,
  input wire logic multiplexed_terminal_o,
  input wire logic switch_signal_output_o,
  input wire logic board_relay_o,
  input wire logic extension_relay_o,
  input wire logic transistor_output_one_o,
  input wire logic extension_transistor_output_o
);
  logic tch_reg;
  logic edg_reg;
  logic last_reg;
  logic [15:0] run_reg;
  // any write may move a selector, so default checks stop there
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tch_reg <= 1'b0;
      edg_reg <= 1'b0;
      last_reg <= 1'b0;
      run_reg <= 16'h0000;
    end else begin
      tch_reg <= tch_reg | avs_write_i;
      last_reg <= multiplexed_terminal_o;
      edg_reg <= edg_reg | (multiplexed_terminal_o != last_reg);
      if (multiplexed_terminal_o != last_reg) begin
        run_reg <= 16'h0000;
      end else if (run_reg != 16'hffff) begin
        run_reg <= run_reg + 16'h0001;
      end
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  a_relay_fault_stop: assert property (
    !tch_reg && !avs_write_i |=> board_relay_o == $past(fault_stop_i))
    else $error("relay does not follow fault stop");
  a_run_level: assert property (
    !tch_reg && !avs_write_i |=> transistor_output_one_o == $past(drive_running_i))
    else $error("transistor output does not follow running");
  a_reached_level: assert property (
    !tch_reg && !avs_write_i |=> extension_transistor_output_o == $past(freq_reached_i))
    else $error("extension transistor does not follow frequency reached");
  a_switch_off: assert property (
    !tch_reg |-> !switch_signal_output_o)
    else $error("switch output active with code zero");
  a_ext_relay_off: assert property (
    $rose(extension_relay_o) |-> $past(tch_reg))
    else $error("extension relay rose with code zero");
  a_pulse_spacing: assert property (
    !tch_reg && edg_reg && multiplexed_terminal_o != last_reg |-> run_reg >= 16'h0270)
    else $error("pulse half period too short");
  a_wait_once: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest held more than one cycle");
  a_reset_clear: assert property (
    $fell(sys_rst_i) |-> !board_relay_o && !transistor_output_one_o)
    else $error("outputs active at reset release");
endmodule
bind drive_output_terminal_mux drive_output_terminal_mux_properties chk_u (.clk_sys_i,
  .sys_rst_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .drive_running_i,
  .fault_stop_i, .freq_reached_i, .multiplexed_terminal_o, .switch_signal_output_o,
  .board_relay_o, .extension_relay_o, .transistor_output_one_o,
  .extension_transistor_output_o);

// ===== verification/field_wiring_model.sv
// field side of the multiplexed terminal: measures its toggle spacing
// assumes the terminal is sampled on the system clock
`timescale 1ns/1ps
module field_wiring_model
(
  input wire logic clk_sys_i,
  input wire logic clr_i,
  input wire logic term_i,
  output int min_run_o,
  output int edges_o
);
  int run;
  logic last;
  // first change only starts the count, its spacing is meaningless
  always @(posedge clk_sys_i) begin
    run <= run + 1;
    if (clr_i) begin
      edges_o <= 0;
      min_run_o <= 100000;
    end else if (term_i !== last) begin
      edges_o <= edges_o + 1;
      run <= 1;
      if (edges_o > 0 && run < min_run_o) begin
        min_run_o <= run;
      end
    end
    last <= term_i;
  end
endmodule
